// ===== verilog/clockgen_config_regs.sv
/*
  Configuration and identification register bank of an eight-output
  differential clock generator, reached as an SMBus slave with block read
  and block write transfers, and driving the controls of the analog core.
  Assumes SCL, SDA, straps and output-enable pins are asynchronous to clock
  and slow enough to be sampled by it; the SDA wire is resolved outside.
*/
// Operation
// - Cleared enable bit overrides output-enable pin
// - Byte 1 top bits return latched spread strap
// - Byte 1 bit 5 picks spread source
// - Byte 1 bits 4:3 software spread amount
// - Software spread acts only when selected
// - Byte 1 bits 1:0 select output amplitude
// - Byte 2 per-output slew, powers up fast
// - Byte 3 bits 7:6 reference slew rate
// - Byte 3 bit 5 reference wake-on-LAN enable
// - Byte 3 bit 4 reference output enable
// - Byte 5 read-only revision and vendor codes
// - Byte 6 read-only part kind and identifier
// - Byte 7 block read length, powers up 8
// - Answer only own address with strap bit
// - Block write: index, count, then data bytes
// - Block read: count first, then data bytes
// - Keep every completed byte when stopped early
`timescale 1ns/10ps
`include "clockgen_map.svh"

module clockgen_config_regs #(
  parameter int          NUM_OUTPUTS     = 8,
  parameter logic [3:0]  REVISION_CODE   = 4'h5,  // Arbitrary value
  parameter logic [3:0]  VENDOR_CODE     = 4'h9,  // Arbitrary value
  parameter logic [1:0]  PART_KIND       = 2'h0,  // Clock generator kind
  parameter logic [5:0]  PART_IDENTIFIER = 6'h2D  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   sysRst,
  // SMBus pins
  input  wire logic                   sclIn,
  input  wire logic                   sdaIn,
  output logic                        sdaOut,
  output logic                        sdaDriveN,
  // Straps and output-enable pins
  input  wire logic                   spreadStrapAboveLow,
  input  wire logic                   spreadStrapAboveMid,
  input  wire logic                   slaveAddressStrap,
  input  wire logic [NUM_OUTPUTS-1:0] outEnablePinsN,
  // Controls to the analog core
  output logic      [NUM_OUTPUTS-1:0] diffOutOn,
  output logic      [NUM_OUTPUTS-1:0] diffEdgeFast,
  output logic      [1:0]             swingSelect,
  output logic      [1:0]             spreadAmount,
  output logic      [1:0]             refEdgeSpeed,
  output logic                        refRun,
  output logic                        refWakeOnLan
);

  // ****************************************
  // Elaboration check
  // ****************************************
  // Each output owns one bit of a byte-wide register
  if (NUM_OUTPUTS != 8) begin : g_bad_width
    $error("NUM_OUTPUTS must be 8");
  end

  localparam int PW = NUM_OUTPUTS + 5;

  // ****************************************
  // Declarations
  // ****************************************
  logic [PW-1:0]                  pinMeta_reg;
  logic [PW-1:0]                  pinSync_reg;
  logic                           sclLast_reg;
  logic                           sdaLast_reg;
  logic                           sclNow;
  logic                           sdaNow;
  logic                           sclRise;
  logic                           sclFall;
  logic                           startCond;
  logic                           stopCond;
  logic [1:0]                     strapWait_reg;
  logic                           strapDone_reg;
  logic [1:0]                     strapSpread_reg;
  logic                           addrStrap_reg;
  logic [NUM_OUTPUTS-1:0]         oeMask_reg;
  logic [NUM_OUTPUTS-1:0]         edgeSpeed_reg;
  logic                           spreadSel_reg;
  logic [1:0]                     spreadAmt_reg;
  logic [1:0]                     swing_reg;
  logic [1:0]                     refEdge_reg;
  logic                           refWol_reg;
  logic                           refOe_reg;
  logic [4:0]                     blockLen_reg;
  clockgen_pkg::smbus_state_type  state_reg;
  logic [3:0]                     bitCnt_reg;
  logic [1:0]                     byteNum_reg;
  logic [7:0]                     rxShift_reg;
  logic [7:0]                     txShift_reg;
  logic [7:0]                     ptr_reg;
  logic                           rwRead_reg;
  logic                           hostNack_reg;
  logic                           byteDone;
  logic                           addrMatch;
  logic                           wrData;
  logic [7:0]                     rdByte;
  logic [7:0]                     countByte;

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  // Two flops on every asynchronous pin
  always_ff @(posedge clock) begin
    if (sysRst) begin
      pinMeta_reg <= {PW{1'b1}};
      pinSync_reg <= {PW{1'b1}};
    end else begin
      pinMeta_reg <= {outEnablePinsN, slaveAddressStrap, spreadStrapAboveMid,
                      spreadStrapAboveLow, sdaIn, sclIn};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Previous line levels for edge finding
  always_ff @(posedge clock) begin
    if (sysRst) begin
      sclLast_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
    end else begin
      sclLast_reg <= sclNow;
      sdaLast_reg <= sdaNow;
    end
  end

  // Clock edges, start and stop
  assign sclNow    = pinSync_reg[0];
  assign sdaNow    = pinSync_reg[1];
  assign sclRise   = sclNow & ~sclLast_reg;
  assign sclFall   = ~sclNow & sclLast_reg;
  assign startCond = sclNow & sclLast_reg & sdaLast_reg & ~sdaNow;
  assign stopCond  = sclNow & sclLast_reg & ~sdaLast_reg & sdaNow;

  // ****************************************
  // Strap latch
  // ****************************************
  // Straps caught once, after the synchronisers settle
  always_ff @(posedge clock) begin
    if (sysRst) begin
      strapWait_reg   <= 2'h0;
      strapDone_reg   <= 1'b0;
      strapSpread_reg <= 2'h0;
      addrStrap_reg   <= 1'b0;
    end else if (!strapDone_reg) begin
      if (strapWait_reg == `STRAP_SETTLE) begin
        strapSpread_reg <= {pinSync_reg[3], pinSync_reg[2]};
        addrStrap_reg   <= pinSync_reg[4];
        strapDone_reg   <= 1'b1;
      end else begin
        strapWait_reg <= strapWait_reg + 2'h1;
      end
    end
  end

  // ****************************************
  // Register read view
  // ****************************************
  // Byte seen by the host at a given index
  function automatic logic [7:0] readReg(input logic [7:0] idx);
    logic [7:0] val;
    val = `UNUSED_VAL;
    case (idx)
      `IDX_OE_MASK:    val = oeMask_reg;
      `IDX_SPREAD:     val = {strapSpread_reg, spreadSel_reg, spreadAmt_reg,
                              `RSVD_SPREAD_VAL, swing_reg};
      `IDX_EDGE_SPEED: val = edgeSpeed_reg;
      `IDX_REF_CTRL:   val = {refEdge_reg, refWol_reg, refOe_reg, `RSVD_REF_VAL};
      `IDX_REV_VENDOR: val = {REVISION_CODE, VENDOR_CODE};
      `IDX_PART_TYPE:  val = {PART_KIND, PART_IDENTIFIER};
      `IDX_BLOCK_LEN:  val = {`RSVD_BLK_VAL, blockLen_reg};
      default:         val = `UNUSED_VAL;
    endcase
    return val;
  endfunction

  assign rdByte    = readReg(ptr_reg);
  assign countByte = {`RSVD_BLK_VAL, blockLen_reg};

  // ****************************************
  // Byte decode
  // ****************************************
  // Completed byte, address match and data store strobe
  assign byteDone  = (state_reg == clockgen_pkg::ST_RECV) && sclFall && (bitCnt_reg == `BYTE_BITS);
  assign addrMatch = rxShift_reg[7:1] == {`SLAVE_ADDR_HI, addrStrap_reg, `SLAVE_ADDR_LO};
  assign wrData    = byteDone && (byteNum_reg == `BYTE_DATA) && !rwRead_reg;

  // ****************************************
  // Writable registers
  // ****************************************
  // Each completed data byte lands at once
  always_ff @(posedge clock) begin
    if (sysRst) begin
      oeMask_reg    <= `RST_OE_MASK;
      spreadSel_reg <= `RST_SPR_SEL;
      spreadAmt_reg <= `RST_SPR_AMT;
      swing_reg     <= `RST_SWING;
      edgeSpeed_reg <= `RST_EDGE_SPEED;
      refEdge_reg   <= `RST_REF_EDGE;
      refWol_reg    <= `RST_REF_WOL;
      refOe_reg     <= `RST_REF_OE;
      blockLen_reg  <= `RST_BLOCK_LEN;
    end else if (wrData) begin
      case (ptr_reg)
        `IDX_OE_MASK: oeMask_reg <= rxShift_reg;
        `IDX_SPREAD: begin
          spreadSel_reg <= rxShift_reg[`SPR_SEL_BIT];
          spreadAmt_reg <= rxShift_reg[`SPR_AMT_HI:`SPR_AMT_LO];
          swing_reg     <= rxShift_reg[`SWING_HI:`SWING_LO];
        end
        `IDX_EDGE_SPEED: edgeSpeed_reg <= rxShift_reg;
        `IDX_REF_CTRL: begin
          refEdge_reg <= rxShift_reg[`REF_EDGE_HI:`REF_EDGE_LO];
          refWol_reg  <= rxShift_reg[`REF_WOL_BIT];
          refOe_reg   <= rxShift_reg[`REF_OE_BIT];
        end
        `IDX_BLOCK_LEN: blockLen_reg <= rxShift_reg[`BLK_LEN_HI:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // SMBus slave engine
  // ****************************************
  // Bit and byte sequencing; SDA is only ever pulled low
  always_ff @(posedge clock) begin
    if (sysRst) begin
      state_reg    <= clockgen_pkg::ST_IDLE;
      bitCnt_reg   <= 4'h0;
      byteNum_reg  <= `BYTE_ADDR;
      rxShift_reg  <= 8'h00;
      txShift_reg  <= 8'h00;
      ptr_reg      <= 8'h00;
      rwRead_reg   <= 1'b0;
      hostNack_reg <= 1'b0;
      sdaDriveN    <= 1'b1;
      sdaOut       <= 1'b0;
    end else if (startCond) begin
      // Start or repeated start
      state_reg   <= clockgen_pkg::ST_RECV;
      bitCnt_reg  <= 4'h0;
      byteNum_reg <= `BYTE_ADDR;
      sdaDriveN   <= 1'b1;
    end else if (stopCond) begin
      state_reg <= clockgen_pkg::ST_IDLE;
      sdaDriveN <= 1'b1;
    end else begin
      case (state_reg)
        clockgen_pkg::ST_IDLE: ;
        clockgen_pkg::ST_RECV: begin
          if (sclRise && bitCnt_reg != `BYTE_BITS) begin
            rxShift_reg <= {rxShift_reg[6:0], sdaNow};
            bitCnt_reg  <= bitCnt_reg + 4'h1;
          end else if (byteDone) begin
            if (byteNum_reg == `BYTE_ADDR && !addrMatch) begin
              state_reg <= clockgen_pkg::ST_IDLE;
            end else begin
              state_reg <= clockgen_pkg::ST_ACK;
              sdaDriveN <= 1'b0;
            end
            if (byteNum_reg == `BYTE_ADDR) begin
              rwRead_reg <= rxShift_reg[0];
            end
            if (byteNum_reg == `BYTE_INDEX) begin
              ptr_reg <= rxShift_reg;
            end
            if (wrData) begin
              ptr_reg <= ptr_reg + 8'h01;
            end
          end
        end
        clockgen_pkg::ST_ACK: begin
          if (sclFall) begin
            bitCnt_reg <= 4'h0;
            if (rwRead_reg && byteNum_reg == `BYTE_ADDR) begin
              state_reg   <= clockgen_pkg::ST_SEND;
              txShift_reg <= countByte;
              sdaDriveN   <= countByte[7];
            end else begin
              state_reg <= clockgen_pkg::ST_RECV;
              sdaDriveN <= 1'b1;
              if (byteNum_reg != `BYTE_DATA) begin
                byteNum_reg <= byteNum_reg + 2'h1;
              end
            end
          end
        end
        clockgen_pkg::ST_SEND: begin
          if (sclFall) begin
            if (bitCnt_reg == `LAST_TX_BIT) begin
              state_reg <= clockgen_pkg::ST_HOSTACK;
              sdaDriveN <= 1'b1;
            end else begin
              txShift_reg <= {txShift_reg[6:0], 1'b0};
              sdaDriveN   <= txShift_reg[6];
              bitCnt_reg  <= bitCnt_reg + 4'h1;
            end
          end
        end
        clockgen_pkg::ST_HOSTACK: begin
          if (sclRise) begin
            hostNack_reg <= sdaNow;
          end else if (sclFall) begin
            if (hostNack_reg) begin
              state_reg <= clockgen_pkg::ST_IDLE;
            end else begin
              state_reg   <= clockgen_pkg::ST_SEND;
              txShift_reg <= rdByte;
              sdaDriveN   <= rdByte[7];
              ptr_reg     <= ptr_reg + 8'h01;
              bitCnt_reg  <= 4'h0;
            end
          end
        end
        default: begin
          state_reg <= clockgen_pkg::ST_IDLE;
          sdaDriveN <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Analog core controls
  // ****************************************
  // Registered controls; a cleared enable bit beats the pin
  always_ff @(posedge clock) begin
    if (sysRst) begin
      diffOutOn    <= {NUM_OUTPUTS{1'b0}};
      diffEdgeFast <= `RST_EDGE_SPEED;
      swingSelect  <= `RST_SWING;
      spreadAmount <= `RST_SPR_AMT;
      refEdgeSpeed <= `RST_REF_EDGE;
      refRun       <= `RST_REF_OE;
      refWakeOnLan <= `RST_REF_WOL;
    end else begin
      diffOutOn    <= oeMask_reg & ~pinSync_reg[PW-1:5];
      diffEdgeFast <= edgeSpeed_reg;
      swingSelect  <= swing_reg;
      spreadAmount <= spreadSel_reg ? spreadAmt_reg : strapSpread_reg;
      refEdgeSpeed <= refEdge_reg;
      refRun       <= refOe_reg;
      refWakeOnLan <= refWol_reg;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sysRst);

  sequence addrByteDone;
    byteDone && byteNum_reg == `BYTE_ADDR;
  endsequence

  sequence readTurnaround;
    state_reg == clockgen_pkg::ST_ACK && sclFall && rwRead_reg && byteNum_reg == `BYTE_ADDR;
  endsequence

  chk_oe_override: assert property (
    1'b1 |=> (diffOutOn & ~$past(oeMask_reg)) == 8'h00)
    else $error("disabled output still on");

  chk_spread_software: assert property (
    spreadSel_reg |=> spreadAmount == $past(spreadAmt_reg))
    else $error("software spread not applied");

  chk_spread_strap: assert property (
    !spreadSel_reg |=> spreadAmount == $past(strapSpread_reg))
    else $error("strap spread not applied");

  chk_power_up_values: assert property (
    $past(sysRst) |-> oeMask_reg == `RST_OE_MASK && blockLen_reg == `RST_BLOCK_LEN
      && edgeSpeed_reg == `RST_EDGE_SPEED && swing_reg == `RST_SWING)
    else $error("wrong power-up value");

  chk_addr_refused: assert property (
    addrByteDone ##0 !addrMatch |=> state_reg == clockgen_pkg::ST_IDLE && sdaDriveN)
    else $error("foreign address acknowledged");

  chk_ack_held: assert property (
    byteDone && (byteNum_reg != `BYTE_ADDR || addrMatch) |=> !sdaDriveN throughout (!sclFall [*2]))
    else $error("acknowledge not driven");

  chk_write_store: assert property (
    wrData && ptr_reg == `IDX_OE_MASK |=> oeMask_reg == $past(rxShift_reg))
    else $error("written byte not kept");

  chk_count_first: assert property (
    readTurnaround |=> txShift_reg == {`RSVD_BLK_VAL, $past(blockLen_reg)} && !sdaDriveN)
    else $error("block read does not open with count");

  chk_nack_ends: assert property (
    state_reg == clockgen_pkg::ST_HOSTACK && sclFall && hostNack_reg
      |=> state_reg == clockgen_pkg::ST_IDLE && sdaDriveN)
    else $error("transfer continues after not-acknowledge");

  chk_ids_fixed: assert property (
    wrData && ptr_reg == `IDX_REV_VENDOR |=> readReg(`IDX_REV_VENDOR) == {REVISION_CODE, VENDOR_CODE}
      && $stable(oeMask_reg) && $stable(edgeSpeed_reg) && $stable(blockLen_reg))
    else $error("identity byte changed by write");

endmodule

// ===== verilog/clockgen_map.svh
/*
  Register map of the clock generator configuration bank: register indexes,
  field positions, power-up values, reserved read values and protocol counts.
  Assumes it is included by bare name from the design file that uses it.
*/
`ifndef CLOCKGEN_MAP_SVH
`define CLOCKGEN_MAP_SVH

// ****************************************
// Register indexes
// ****************************************
`define IDX_OE_MASK      8'h00
`define IDX_SPREAD       8'h01
`define IDX_EDGE_SPEED   8'h02
`define IDX_REF_CTRL     8'h03
`define IDX_UNUSED       8'h04
`define IDX_REV_VENDOR   8'h05
`define IDX_PART_TYPE    8'h06
`define IDX_BLOCK_LEN    8'h07

// ****************************************
// Field positions
// ****************************************
`define SPR_SEL_BIT      5
`define SPR_AMT_HI       4
`define SPR_AMT_LO       3
`define SWING_HI         1
`define SWING_LO         0
`define REF_EDGE_HI      7
`define REF_EDGE_LO      6
`define REF_WOL_BIT      5
`define REF_OE_BIT       4
`define BLK_LEN_HI       4

// ****************************************
// Power-up and reserved values
// ****************************************
`define RST_OE_MASK      8'hFF
`define RST_EDGE_SPEED   8'hFF
`define RST_SWING        2'h2
`define RST_SPR_SEL      1'h0
`define RST_SPR_AMT      2'h0
`define RST_REF_EDGE     2'h1
`define RST_REF_WOL      1'h0
`define RST_REF_OE       1'h1
`define RST_BLOCK_LEN    5'h08
`define RSVD_SPREAD_VAL  1'h1
`define RSVD_REF_VAL     4'hF
`define RSVD_BLK_VAL     3'h0
`define UNUSED_VAL       8'h00

// ****************************************
// Slave address and protocol counts
// ****************************************
`define SLAVE_ADDR_HI    5'h1A
`define SLAVE_ADDR_LO    1'h0
`define BYTE_BITS        4'h8
`define LAST_TX_BIT      4'h7
`define STRAP_SETTLE     2'h3
`define BYTE_ADDR        2'h0
`define BYTE_INDEX       2'h1
`define BYTE_DATA        2'h3

`endif

// ===== verilog/clockgen_pkg.sv
/*
  Types shared by the clock generator configuration bank.
  Assumes nothing of its surroundings.
*/
package clockgen_pkg;

  // SMBus slave engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK,
    ST_SEND,
    ST_HOSTACK
  } smbus_state_type;

endpackage

// ===== sim/smbus_host_model.sv
/*
  Behavioural SMBus host: start, stop, byte write and byte read with
  acknowledge, 80 ns bit period, open-drain data enable (low drives low).
  Assumes SDA is resolved outside from all enables with a pull-up.
*/
`timescale 1ns/10ps

module smbus_host_model (
  // SMBus pins
  output logic       scl      = 1'b1,
  output logic       sdaHostN = 1'b1,
  input  wire logic  sda,
  // Last byte read and its toggle
  output logic [7:0] rxByte   = 8'h00,
  output logic       rxToggle = 1'b0
);
  // ****************************************
  // Bus conditions
  // ****************************************
  // Start or repeated start: data falls while clock is high
  task automatic start_cond();
    sdaHostN = 1'b1;
    #40 scl = 1'b1;
    #40 sdaHostN = 1'b0;
    #40 scl = 1'b0;
  endtask

  // Stop: data rises while clock is high, clock then stands high
  task automatic stop_cond();
    sdaHostN = 1'b0;
    #40 scl = 1'b1;
    #40 sdaHostN = 1'b1;
    #40;
  endtask

  // ****************************************
  // Byte transfers
  // ****************************************
  // Shift out MSB first, then sample the acknowledge at the end of its high phase
  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #20 sdaHostN = d[i];
      #20 scl = 1'b1;
      #40 scl = 1'b0;
    end
    #20 sdaHostN = 1'b1;
    #20 scl = 1'b1;
    #30 ack = sda;
    #10 scl = 1'b0;
  endtask

  // Sample eight bits late in each high phase, then acknowledge or refuse
  task automatic recv_byte(input logic nack);
    logic [7:0] d;
    sdaHostN = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #40 scl = 1'b1;
      #30 d[i] = sda;
      #10 scl = 1'b0;
    end
    #20 sdaHostN = nack;
    #20 scl = 1'b1;
    #40 scl = 1'b0;
    rxByte = d;
    rxToggle = ~rxToggle;
  endtask
endmodule

// ===== sim/tb_clockgen_config_regs.sv
/*
  Self-checking bench for the clock generator configuration bank.
  Assumes the design files and the SMBus host model are compiled first.
*/
`timescale 1ns/10ps

module tb_clockgen_config_regs;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [3:0] REV = 4'h5;  // Arbitrary value
  localparam logic [3:0] VEN = 4'h9;  // Arbitrary value
  localparam logic [5:0] PID = 6'h2D; // Arbitrary value
  logic       clock  = 1'b0;
  logic       sysRst = 1'b1;
  logic       scl, sdaHostN, sdaOut, sdaDriveN, rxToggle, ack, addrStrap, refRun, refWakeOnLan;
  logic [1:0] strap, swingSelect, spreadAmount, refEdgeSpeed;
  logic [7:0] pinsN, diffOutOn, diffEdgeFast, rxByte, addrW;
  logic [7:0] sh[0:7];
  logic [7:0] wbuf[0:7];
  logic [7:0] expQ[$];
  logic [31:0] rnd;
  int         seed = 221;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycles = 0;
  wire        sda = sdaHostN & (sdaDriveN | sdaOut);

  // Clock at 100 MHz
  always #5 clock = ~clock;

  // ****************************************
  // Instances
  // ****************************************
  clockgen_config_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEN), .PART_KIND(2'h0), .PART_IDENTIFIER(PID))
    clockgen_config_regs_inst (.clock(clock), .sysRst(sysRst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaDriveN(sdaDriveN), .spreadStrapAboveLow(strap[0]), .spreadStrapAboveMid(strap[1]),
    .slaveAddressStrap(addrStrap), .outEnablePinsN(pinsN), .diffOutOn(diffOutOn), .diffEdgeFast(diffEdgeFast),
    .swingSelect(swingSelect), .spreadAmount(spreadAmount), .refEdgeSpeed(refEdgeSpeed), .refRun(refRun),
    .refWakeOnLan(refWakeOnLan));

  smbus_host_model smbus_host_model_inst (.scl(scl), .sdaHostN(sdaHostN), .sda(sda), .rxByte(rxByte),
    .rxToggle(rxToggle));

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected read value of a register from the shadow copy
  function automatic logic [7:0] rd_val(input logic [7:0] i);
    case (i)
      8'h00: rd_val = sh[0];
      8'h01: rd_val = {strap, sh[1][5:3], 1'b1, sh[1][1:0]};
      8'h02: rd_val = sh[2];
      8'h03: rd_val = {sh[3][7:4], 4'hF};
      8'h05: rd_val = {REV, VEN};
      8'h06: rd_val = {2'h0, PID};
      8'h07: rd_val = {3'h0, sh[7][4:0]};
      default: rd_val = 8'h00;
    endcase
  endfunction

  // Control outputs against the shadow copy and the pins
  task automatic check_ports();
    check(diffOutOn, sh[0] & ~pinsN);
    check(diffEdgeFast, sh[2]);
    check(swingSelect, sh[1][1:0]);
    check(spreadAmount, sh[1][5] ? sh[1][4:3] : strap);
    check(refEdgeSpeed, sh[3][7:6]);
    check(refRun, sh[3][4]);
    check(refWakeOnLan, sh[3][5]);
  endtask

  // ****************************************
  // Transfers
  // ****************************************
  task automatic send(input logic [7:0] d, input logic exp);
    smbus_host_model_inst.send_byte(d, ack);
    check(ack, exp);
  endtask

  // Block write of n data bytes from wbuf, announced count cnt
  task automatic blk_write(input logic [7:0] idx, input logic [7:0] cnt, input int n);
    smbus_host_model_inst.start_cond();
    send(addrW, 1'b0);
    send(idx, 1'b0);
    send(cnt, 1'b0);
    for (int k = 0; k < n; k++) begin
      send(wbuf[k], 1'b0);
      if (idx + k < 8) sh[idx+k] = wbuf[k];
    end
    smbus_host_model_inst.stop_cond();
    repeat (8) @(posedge clock);
    #1;
  endtask

  // Block read: count byte first, then n data bytes, last one refused
  task automatic blk_read(input logic [7:0] idx, input int n);
    expQ.push_back(rd_val(8'h07));
    for (int k = 0; k < n; k++) expQ.push_back(rd_val(8'(idx + k)));
    smbus_host_model_inst.start_cond();
    send(addrW, 1'b0);
    send(idx, 1'b0);
    smbus_host_model_inst.start_cond();
    send(addrW | 8'h01, 1'b0);
    for (int k = 0; k <= n; k++) smbus_host_model_inst.recv_byte(k == n);
    smbus_host_model_inst.stop_cond();
  endtask

  // Each byte read is compared with the oldest note
  always @(rxToggle) begin
    if (!sysRst) check(rxByte, expQ.pop_front());
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sh = '{8'hFF, 8'h06, 8'hFF, 8'h5F, 8'h00, 8'h00, 8'h00, 8'h08};
    rnd = $random(seed);
    strap = (rnd[1:0] == 2'b10) ? 2'b11 : rnd[1:0];
    addrStrap = rnd[2];
    pinsN = rnd[15:8];
    addrW = {5'h1A, addrStrap, 2'b00};
    repeat (2) @(posedge clock);
    #1 sysRst = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    check_ports();
    blk_read(8'h00, 8);
    // Foreign addresses are refused
    smbus_host_model_inst.start_cond();
    send(addrW ^ 8'h04, 1'b1);
    smbus_host_model_inst.stop_cond();
    smbus_host_model_inst.start_cond();
    send(addrW ^ 8'h80, 1'b1);
    smbus_host_model_inst.stop_cond();
    // Whole bank written at random, software spread left unselected
    for (int k = 0; k < 8; k++) wbuf[k] = 8'($random(seed));
    wbuf[1][5:3] = 3'b011;
    blk_write(8'h00, 8'h08, 8);
    check_ports();
    blk_read(8'h00, 8);
    // Spread codes 0, 1 and 3, every swing and reference slew code
    for (int i = 0; i < 4; i++) begin
      wbuf[1] = 8'($random(seed));
      wbuf[0] = {wbuf[1][7:6], 1'b1, (i == 2) ? 2'b11 : i[1:0], wbuf[1][2], i[1:0]};
      wbuf[2] = {i[1:0], wbuf[1][5:0]};
      blk_write(8'h01, 8'h03, 3);
      check_ports();
    end
    blk_read(8'h05, 4);
    // Write stopped after its first data byte
    wbuf[0] = ~sh[0];
    wbuf[1] = 8'h00;
    blk_write(8'h00, 8'h03, 1);
    check_ports();
    blk_read(8'h00, 2);
    // Output-enable pins sweep
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) #1 pinsN = 8'($random(seed));
      repeat (6) @(posedge clock);
      #1;
      check_ports();
    end
    // Second reset restores power-up values
    @(posedge clock) #1 sysRst = 1'b1;
    repeat (2) @(posedge clock);
    #1 sysRst = 1'b0;
    sh = '{8'hFF, 8'h06, 8'hFF, 8'h5F, 8'h00, 8'h00, 8'h00, 8'h08};
    repeat (12) @(posedge clock);
    #1;
    check_ports();
    blk_read(8'h00, 8);
    check(8'(expQ.size()), 8'h00);
    test_done();
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  // Verdict and end of run
  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
endmodule
